// File: bench/anp_core_tb.sv
// anp_core_tb: self-checking bench of the negotiation block
`timescale 1ns/10ps

module anp_core_tb
	import anp_pkg::*;
;
	logic        hclk, hresetn, hwrite, hreadyout, hresp, flp_tx_on, an_complete, lp_word_valid;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] word, lp_word, flp_tx_word, q;
	anp_media_s  send, media_raw;
	anp_tech_s   tech;
	int          err_count, n_tests;

	anp_core #(.NEG_LIMIT(200)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .media_raw(media_raw), .lp_word(lp_word),
		.lp_word_valid(lp_word_valid), .tech(tech), .flp_tx_word(flp_tx_word), .flp_tx_on(flp_tx_on),
		.an_complete(an_complete));
	anp_partner part_u (.hclk(hclk), .hresetn(hresetn), .send(send), .word(word), .flp_tx_on(flp_tx_on),
		.media_raw(media_raw), .lp_word(lp_word), .lp_word_valid(lp_word_valid));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task summarize;
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task hang;
		err_count++;
		$display("BAD t=%0t wait ran out", $time);
		summarize();
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one ahb-lite single transfer; q holds read data
	task bus(input logic w, input logic [4:0] idx, input logic [15:0] d);
		int k;
		htrans <= ANP_HTRANS_NSEQ;
		haddr  <= {25'h0, idx, 2'h0};
		hwrite <= w;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 50) hang();
			@(posedge hclk);
		end
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 50) hang();
			@(posedge hclk);
		end
		q = hrdata[15:0];
		chk({15'h0, hresp}, 16'h0, "hresp");
	endtask

	task wait_c(input logic v);
		int k;
		k = 0;
		while (an_complete !== v) begin
			k++;
			if (k > 400) hang();
			@(posedge hclk);
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task t_reset;
		chk({15'h0, flp_tx_on}, 16'h1, "bursts after reset");
		bus(0, ANP_IDX_CTRL, 0);
		chk(q, 16'h1000, "ctrl reset");
		bus(0, ANP_IDX_ADV, 0);
		chk(q, 16'h01e1, "advert reset");
		bus(0, ANP_IDX_STAT, 0);
		chk(q, 16'h7808, "status reset");
		bus(1, ANP_IDX_LPA, 16'hffff);
		bus(0, ANP_IDX_LPA, 0);
		chk(q, 16'h0, "partner word read only");
		bus(0, 5'h1f, 0);
		chk(q, 16'h0, "unmapped read");
		$display("done reset");
	endtask

	task t_nlp;
		send <= '{flp:0, nlp:1, idle100:0, signal:1, link_ok:1};
		wait_c(1);
		chk({13'h0, tech}, 16'h0002, "nlp tech");
		bus(0, ANP_IDX_LPA, 0);
		chk(q, 16'h0020, "nlp partner bit");
		bus(0, ANP_IDX_EXP, 0);
		chk(q, 16'h0, "nlp expansion");
		bus(0, ANP_IDX_STAT, 0);
		chk(q, 16'h782c, "nlp status");
		bus(0, ANP_IDX_QSTAT, 0);
		chk(q & 16'hc71b, 16'h0411, "nlp consolidated");
		$display("done nlp");
	endtask

	task t_restart;
		send <= '0;
		repeat (6) @(posedge hclk);
		bus(1, ANP_IDX_CTRL, 16'h1200);
		wait_c(0);
		bus(0, ANP_IDX_CTRL, 0);
		chk(q, 16'h1000, "restart bit stuck");
		bus(0, ANP_IDX_QSTAT, 0);
		chk({13'h0, q[10:8]}, 16'h4, "progress lost on restart");
		bus(0, ANP_IDX_QSTAT, 0);
		chk({13'h0, q[10:8]}, 16'h1, "progress after read");
		chk({15'h0, q[3]}, 16'h1, "no signal bit");
		$display("done restart");
	endtask

	task t_idle;
		send <= '{flp:0, nlp:0, idle100:1, signal:1, link_ok:1};
		repeat (6) @(posedge hclk);
		bus(1, ANP_IDX_CTRL, 16'h0);
		bus(1, ANP_IDX_CTRL, 16'h1000);
		wait_c(1);
		chk({13'h0, tech}, 16'h0004, "idle tech");
		bus(0, ANP_IDX_LPA, 0);
		chk(q, 16'h0080, "idle partner bit");
		bus(0, ANP_IDX_EXP, 0);
		chk(q, 16'h0, "idle expansion");
		$display("done idle");
	endtask

	task t_flp;
		send <= '{flp:1, nlp:0, idle100:0, signal:1, link_ok:1};
		word <= 16'h2101;
		repeat (6) @(posedge hclk);
		bus(1, ANP_IDX_ADV, 16'h01e1); // clears the fault bit left set by the earlier link loss
		bus(1, ANP_IDX_CTRL, 16'h1200);
		wait_c(0);
		wait_c(1);
		chk({13'h0, tech}, 16'h0005, "resolved mode");
		chk(flp_tx_word, 16'h01e1, "burst word");
		bus(0, ANP_IDX_LPA, 0);
		chk(q, 16'h2101, "partner word");
		bus(0, ANP_IDX_EXP, 0);
		chk(q, 16'h0001, "negotiation capable");
		bus(0, ANP_IDX_STAT, 0);
		chk({15'h0, q[ANP_ST_RFAULT]}, 16'h1, "status fault");
		bus(0, ANP_IDX_QSTAT, 0);
		chk(q & 16'hc003, 16'hc003, "consolidated fault");
		bus(0, ANP_IDX_RFLT, 0);
		chk({15'h0, q[ANP_RFLT_BIT]}, 16'h1, "fault word");
		word <= 16'h0041;
		bus(1, ANP_IDX_CTRL, 16'h1200);
		wait_c(0);
		wait_c(1);
		chk({13'h0, tech}, 16'h0003, "ten full duplex mode");
		$display("done flp");
	endtask

	task t_fault;
		send.link_ok <= 1'b0;
		wait_c(0);
		bus(0, ANP_IDX_ADV, 0);
		chk(q, 16'h21e1, "local fault advert");
		send <= '{flp:1, nlp:1, idle100:1, signal:1, link_ok:0};
		repeat (6) @(posedge hclk);
		bus(1, ANP_IDX_CTRL, 16'h1200);
		repeat (20) @(posedge hclk);
		bus(0, ANP_IDX_EXP, 0);
		chk({15'h0, q[ANP_EXP_PDFAULT]}, 16'h1, "detect fault");
		chk({13'h0, tech}, 16'h0, "tech on fault");
		bus(1, ANP_IDX_CTRL, 16'h9000);
		repeat (2) @(posedge hclk);
		chk({15'h0, an_complete}, 16'h0, "complete after reset");
		bus(0, ANP_IDX_QSTAT, 0);
		chk({13'h0, q[10:8]}, 16'h1, "progress after reset");
		bus(0, ANP_IDX_ADV, 0);
		chk(q, 16'h01e1, "advert after reset");
		$display("done fault");
	endtask

	// clock of 25 ns
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// main sequence; every input has a value at time zero
	initial begin
		hresetn   = 1'b0;
		htrans    = 2'h0;
		haddr     = 32'h0;
		hwrite    = 1'b0;
		hwdata    = 32'h0;
		send      = '0;
		word      = 16'h0;
		err_count = 0;
		n_tests   = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_nlp();
		t_restart();
		t_idle();
		t_flp();
		t_fault();
		summarize();
	end
endmodule

// File: bench/anp_partner.sv
// anp_partner: behavioural remote link partner driving the media pins
`timescale 1ns/10ps

module anp_partner
	import anp_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// reply chosen by the bench and the word offered in bursts
	input  wire anp_media_s  send,
	input  wire logic [15:0] word,
	input  wire logic        flp_tx_on,
	// media side towards the block
	output anp_media_s       media_raw,
	output logic      [15:0] lp_word,
	output logic             lp_word_valid
);
	logic [1:0] gap;

	// pins follow the chosen reply; a dropped link_ok is a link failure
	assign media_raw = send;

	// a word every fourth cycle, only while our bursts are heard; stale data toggles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap           <= 2'h0;
			lp_word       <= 16'h0;
			lp_word_valid <= 1'b0;
		end else begin
			gap           <= gap + 2'h1;
			lp_word_valid <= send.flp && flp_tx_on && gap == 2'h3;
			lp_word       <= (send.flp && flp_tx_on && gap == 2'h3) ? word : ~lp_word;
		end
	end
endmodule

// File: core/anp_core.sv
// anp_core: negotiation arbitration, parallel detect and progress monitor with an ahb-lite register slave
//
// Operation
// [RULE1] no burst reply: parallel detect, clear partner_negotiation_capable
// [RULE2] parallel detect sets partner bit 5.5 or 5.7
// [RULE3] parallel detect success sets complete bit
// [RULE4] enable only the detected technology
// [RULE5] link pulses only: partner is 10 only
// [RULE6] scrambled idles: non-negotiating 100 partner
// [RULE7] burst reply sets partner_negotiation_capable
// [RULE8] no receive signal sets signal-absent bit
// [RULE9] several indications: no technology, detect fault
// [RULE10] partner remote fault sets all fault bits
// [RULE11] local link fault advertises remote fault
// [RULE12] negotiate at power-up and on request
// [RULE13] any reset idles machines, clears progress
// [RULE14] restart idles machines, keeps progress bits
// [RULE15] progress changes on read, reset, advance
// [RULE16] progress field only moves upward
// [RULE17] after complete only read or reset
// [RULE18] restart on link fail, restart bit, toggle
// [RULE19] negotiation bounded by five hundred milliseconds
// [RULE20] management polls complete and link status
// [RULE21] resolve mode by fixed priority order
// [RULE22] bursts from advert, partner word stored
// [RULE23] complete mirrored into consolidated status
// [RULE24] restart bit clears itself once begun
`timescale 1ns/10ps

module anp_core
	import anp_pkg::*;
#(
	parameter int NEG_LIMIT = ANP_NEG_CYCLES
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// media side indications (pins) and decoded partner word
	input  wire anp_media_s  media_raw,
	input  wire logic [15:0] lp_word,
	input  wire logic        lp_word_valid,
	// technology control and burst source
	output anp_tech_s        tech,
	output logic      [15:0] flp_tx_word,
	output logic             flp_tx_on,
	output logic             an_complete
);

	typedef struct packed {
		logic                   hreadyout;
		logic [31:0]            hrdata;
		logic                   hresp;
		logic                   dp_write;
		logic                   dp_read;
		logic                   dp_hit;
		logic [4:0]             dp_idx;
		logic                   an_enable;
		logic                   restart_bit;
		logic                   start_pend;
		logic [15:0]            adv;
		logic [15:0]            lpa;
		logic                   lp_able;
		logic                   pd_fault;
		anp_arb_e               arb;
		logic [2:0]             progress;
		logic                   complete;
		logic                   sig_none;
		logic                   rfault;
		logic                   link_fault;
		logic                   tx_flp;
		anp_tech_s              tech;
		logic [ANP_TIMER_W-1:0] timer;
	} anp_state_s;

	localparam anp_state_s ST_RESET = '{
		hreadyout: 1'b1, hrdata: 32'h0000_0000, hresp: ANP_HRESP_OKAY,
		dp_write: 1'b0, dp_read: 1'b0, dp_hit: 1'b0, dp_idx: 5'h00,
		an_enable: 1'b1, restart_bit: 1'b0, start_pend: 1'b1,
		adv: ANP_ADV_RESET, lpa: 16'h0000, lp_able: 1'b0, pd_fault: 1'b0,
		arb: ANP_ARB_IDLE, progress: ANP_PROG_IDLE, complete: 1'b0,
		sig_none: 1'b0, rfault: 1'b0, link_fault: 1'b0, tx_flp: 1'b0,
		tech: 3'h0, timer: '0
	};
	localparam logic [ANP_TIMER_W-1:0] TIMER_END = ANP_TIMER_W'(NEG_LIMIT - 1);

	anp_state_s       s;
	anp_state_s       next_s;
	anp_media_s       m;
	logic [4:0]       media_q;
	logic             addr_fire;
	logic             restart_ev;
	logic             rd_qstat;
	logic             sw_reset;
	logic [1:0]       ind_cnt;
	logic [2:0]       prog_new;

	// ************************************************************
	// helpers
	// ************************************************************

	// progress code of an arbitration state
	function automatic logic [2:0] prog_code(input anp_arb_e a);
		case (a)
			ANP_ARB_ABIL: prog_code = ANP_PROG_ABIL;
			ANP_ARB_ACK:  prog_code = ANP_PROG_ACK;
			ANP_ARB_LCHK: prog_code = ANP_PROG_LCHK;
			ANP_ARB_DONE: prog_code = ANP_PROG_DONE;
			default:      prog_code = ANP_PROG_IDLE;
		endcase
	endfunction

	// highest common technology; no t4 datapath exists, so t4 enables nothing
	function automatic anp_tech_s resolve(input logic [15:0] c);
		resolve = '0;
		if (c[ANP_AB_100FD]) begin
			resolve = '{en_100tx: 1'b1, en_10t: 1'b0, full_duplex: 1'b1}; // RULE21
		end else if (c[ANP_AB_T4]) begin
			resolve = '0;
		end else if (c[ANP_AB_100HD]) begin
			resolve = '{en_100tx: 1'b1, en_10t: 1'b0, full_duplex: 1'b0};
		end else if (c[ANP_AB_10FD]) begin
			resolve = '{en_100tx: 1'b0, en_10t: 1'b1, full_duplex: 1'b1};
		end else if (c[ANP_AB_10HD]) begin
			resolve = '{en_100tx: 1'b0, en_10t: 1'b1, full_duplex: 1'b0};
		end
	endfunction

	// register read decode; unmapped words read as zero
	function automatic logic [15:0] rd_word(input anp_state_s st, input logic [4:0] idx, input logic lnk);
		logic lk;
		lk      = lnk && st.complete;
		rd_word = 16'h0000;
		case (idx)
			ANP_IDX_CTRL: begin
				rd_word[ANP_CTL_ANEN]    = st.an_enable;
				rd_word[ANP_CTL_RESTART] = st.restart_bit;
			end
			ANP_IDX_STAT: begin
				rd_word                  = ANP_STAT_CAPS;
				rd_word[ANP_ST_COMPLETE] = st.complete;
				rd_word[ANP_ST_RFAULT]   = st.rfault;
				rd_word[ANP_ST_ANABLE]   = 1'b1;
				rd_word[ANP_ST_LINK]     = lk;
			end
			ANP_IDX_ADV: rd_word = st.adv;
			ANP_IDX_LPA: rd_word = st.lpa;
			ANP_IDX_EXP: begin
				rd_word[ANP_EXP_LPABLE]  = st.lp_able;
				rd_word[ANP_EXP_PDFAULT] = st.pd_fault;
			end
			ANP_IDX_QSTAT: begin
				rd_word[ANP_QS_SPEED100] = st.tech.en_100tx;
				rd_word[ANP_QS_FULLDUP]  = st.tech.full_duplex;
				rd_word[ANP_QS_PROG_LSB+:3] = st.progress;
				rd_word[ANP_QS_COMPLETE] = st.complete; // RULE23
				rd_word[ANP_QS_SIGNONE]  = st.sig_none;
				rd_word[ANP_QS_RF]       = st.rfault;
				rd_word[ANP_QS_LINK]     = lk;
			end
			ANP_IDX_RFLT: rd_word[ANP_RFLT_BIT] = st.rfault;
			default: rd_word = 16'h0000;
		endcase
	endfunction

	// ************************************************************
	// media synchroniser
	// ************************************************************
	anp_sync #(
		.W($bits(anp_media_s))
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     (media_raw),
		.dout    (media_q)
	);

	assign m         = anp_media_s'(media_q);
	assign addr_fire = hsel && hready && (htrans == ANP_HTRANS_NSEQ);
	assign ind_cnt   = {1'b0, m.flp} + {1'b0, m.nlp} + {1'b0, m.idle100};

	// ************************************************************
	// next-state logic
	// ************************************************************

	// bus first, then restart sources, then arbitration, then progress
	always_comb begin
		anp_state_s rst_v;
		rst_v       = ST_RESET;
		next_s      = s;
		restart_ev  = 1'b0;
		rd_qstat    = 1'b0;
		sw_reset    = 1'b0;
		prog_new    = ANP_PROG_IDLE;
		next_s.dp_write    = 1'b0;
		next_s.dp_read     = 1'b0;
		next_s.hreadyout   = 1'b1;
		next_s.restart_bit = 1'b0; // RULE24

		// reads take one wait state so a preceding write is always seen
		if (s.dp_read) begin
			next_s.hrdata = {16'h0000, s.dp_hit ? rd_word(s, s.dp_idx, m.link_ok) : 16'h0000};
			rd_qstat      = s.dp_hit && (s.dp_idx == ANP_IDX_QSTAT);
			if (s.dp_hit && (s.dp_idx == ANP_IDX_EXP)) begin
				next_s.pd_fault = 1'b0; // a new fault below still sets it
			end
		end
		if (addr_fire) begin
			next_s.dp_idx    = haddr[6:2];
			next_s.dp_hit    = (haddr[31:7] == 25'h0) && (haddr[1:0] == 2'h0);
			next_s.dp_write  = hwrite;
			next_s.dp_read   = !hwrite;
			next_s.hreadyout = hwrite;
		end

		// write data phase
		if (s.dp_write && s.dp_hit) begin
			case (s.dp_idx)
				ANP_IDX_CTRL: begin
					sw_reset         = hwdata[ANP_CTL_SWRST];
					next_s.an_enable = hwdata[ANP_CTL_ANEN];
					if (hwdata[ANP_CTL_ANEN] && (!s.an_enable || hwdata[ANP_CTL_RESTART])) begin
						restart_ev         = 1'b1; // RULE18
						next_s.restart_bit = hwdata[ANP_CTL_RESTART];
					end
				end
				ANP_IDX_ADV: next_s.adv = (hwdata[15:0] & ANP_ADV_WMASK) | (s.adv & ~ANP_ADV_WMASK);
				default: next_s.adv = next_s.adv;
			endcase
		end

		// link loss after completion restarts and flags a local fault
		if ((s.arb == ANP_ARB_DONE) && !m.link_ok) begin
			restart_ev        = 1'b1; // RULE18
			next_s.link_fault = 1'b1;
		end
		if ((s.arb != ANP_ARB_IDLE) && (s.arb != ANP_ARB_DONE)) begin
			next_s.timer = s.timer + 1'b1;
			if (s.timer == TIMER_END) begin
				restart_ev = 1'b1; // RULE19
			end
		end

		// arbitration
		if (!next_s.an_enable) begin
			next_s.arb      = ANP_ARB_IDLE;
			next_s.tech     = '0;
			next_s.complete = 1'b0;
		end else if (restart_ev) begin
			next_s.arb        = ANP_ARB_IDLE; // RULE14
			next_s.start_pend = 1'b1;
			next_s.tech       = '0;
			next_s.complete   = 1'b0;
			next_s.timer      = '0;
		end else begin
			case (s.arb)
				ANP_ARB_IDLE: begin
					if (s.start_pend) begin
						next_s.arb        = ANP_ARB_ABIL; // RULE12
						next_s.start_pend = 1'b0;
						next_s.timer      = '0;
					end
				end
				ANP_ARB_ABIL: begin
					next_s.sig_none = !m.signal; // RULE8
					if (ind_cnt > 2'h1) begin
						next_s.pd_fault = 1'b1; // RULE9
						next_s.tech     = '0;
					end else if (m.flp) begin
						next_s.lp_able = 1'b1; // RULE7
						next_s.arb     = ANP_ARB_ACK;
					end else if (m.nlp) begin
						next_s.lp_able = 1'b0; // RULE1 RULE5
						next_s.lpa     = 16'h0000;
						next_s.lpa[ANP_AB_10HD] = 1'b1; // RULE2
						next_s.tech    = '{en_100tx: 1'b0, en_10t: 1'b1, full_duplex: 1'b0}; // RULE4
						next_s.arb     = ANP_ARB_LCHK;
					end else if (m.idle100) begin
						next_s.lp_able = 1'b0; // RULE6
						next_s.lpa     = 16'h0000;
						next_s.lpa[ANP_AB_100HD] = 1'b1; // RULE2
						next_s.tech    = '{en_100tx: 1'b1, en_10t: 1'b0, full_duplex: 1'b0}; // RULE4
						next_s.arb     = ANP_ARB_LCHK;
					end
				end
				ANP_ARB_ACK: begin
					if (lp_word_valid) begin
						next_s.lpa    = lp_word; // RULE22
						next_s.rfault = lp_word[ANP_AB_RF]; // RULE10
						next_s.tech   = resolve(s.adv & lp_word); // RULE21
						next_s.arb    = ANP_ARB_LCHK;
					end
				end
				ANP_ARB_LCHK: begin
					if (m.link_ok) begin
						next_s.arb        = ANP_ARB_DONE;
						next_s.complete   = 1'b1; // RULE3
						next_s.link_fault = 1'b0;
					end
				end
				ANP_ARB_DONE: next_s.arb = ANP_ARB_DONE;
				default: next_s.arb = ANP_ARB_IDLE;
			endcase
		end

		// hardware set of the advertised fault wins over a software write
		if (next_s.link_fault) begin
			next_s.adv[ANP_AB_RF] = 1'b1; // RULE11
		end
		next_s.tx_flp = (next_s.arb == ANP_ARB_ABIL) || (next_s.arb == ANP_ARB_ACK);

		// progress monitor: a read reloads it, otherwise it only climbs
		prog_new = prog_code(next_s.arb);
		if (rd_qstat) begin
			next_s.progress = prog_new; // RULE15 RULE17
		end else if (prog_new > s.progress) begin
			next_s.progress = prog_new; // RULE16
		end

		// software reset keeps only the bus handshake
		if (sw_reset) begin
			rst_v.hreadyout = next_s.hreadyout; // RULE13
			rst_v.hrdata    = next_s.hrdata;
			rst_v.dp_write  = next_s.dp_write;
			rst_v.dp_read   = next_s.dp_read;
			rst_v.dp_hit    = next_s.dp_hit;
			rst_v.dp_idx    = next_s.dp_idx;
			next_s          = rst_v;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= ST_RESET; // RULE13
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign hreadyout   = s.hreadyout;
	assign hrdata      = s.hrdata;
	assign hresp       = s.hresp;
	assign tech        = s.tech;
	assign flp_tx_word = s.adv; // RULE22
	assign flp_tx_on   = s.tx_flp;
	assign an_complete = s.complete;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_restart_self_clear: assert property (s.restart_bit |=> !s.restart_bit) // RULE24
		else $error("restart bit did not clear itself");
	a_progress_monotonic: assert property ((!rd_qstat && !sw_reset) |=> (s.progress >= $past(s.progress))) // RULE16
		else $error("progress field moved down");
	a_restart_keeps_prog: assert property ((restart_ev && !rd_qstat && !sw_reset) |=>
		(s.arb == ANP_ARB_IDLE) && (s.progress == $past(s.progress))) // RULE14
		else $error("restart changed progress bits");
	a_pd_fault_set: assert property ((s.arb == ANP_ARB_ABIL && ind_cnt > 2'h1 && !restart_ev && next_s.an_enable && !sw_reset)
		|=> s.pd_fault && (s.tech == '0)) // RULE9
		else $error("multiple indications not flagged");
	a_nlp_detect: assert property ((s.arb == ANP_ARB_ABIL && ind_cnt == 2'h1 && m.nlp && !restart_ev
		&& next_s.an_enable && !sw_reset) |=> s.lpa[ANP_AB_10HD] && !s.lp_able && s.tech.en_10t && !s.tech.en_100tx) // RULE5
		else $error("link pulse partner not detected as 10 only");
	a_idle_detect: assert property ((s.arb == ANP_ARB_ABIL && ind_cnt == 2'h1 && m.idle100 && !restart_ev
		&& next_s.an_enable && !sw_reset) |=> s.lpa[ANP_AB_100HD] && !s.lp_able && s.tech.en_100tx) // RULE6
		else $error("idle partner not detected as 100");
	a_flp_capable: assert property ((s.arb == ANP_ARB_ABIL && ind_cnt == 2'h1 && m.flp && !restart_ev
		&& next_s.an_enable && !sw_reset) |=> s.lp_able ##0 (s.arb == ANP_ARB_ACK)) // RULE7
		else $error("burst partner not marked capable");
	a_tech_exclusive: assert property (!(s.tech.en_100tx && s.tech.en_10t)) // RULE4
		else $error("two technologies enabled");
	a_complete_cause: assert property ($rose(s.complete) |-> $past(s.arb == ANP_ARB_LCHK) && (s.arb == ANP_ARB_DONE)) // RULE3
		else $error("complete set without link check");
	a_local_fault_adv: assert property (s.link_fault |-> s.adv[ANP_AB_RF]) // RULE11
		else $error("local fault not advertised");
	a_read_wait: assert property ((addr_fire && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read answer timing wrong");

	c_parallel_10: cover property (s.arb == ANP_ARB_LCHK && s.lpa[ANP_AB_10HD] ##[1:20] s.complete);
	c_negotiated: cover property (s.lp_able && s.arb == ANP_ARB_DONE);
	c_pd_fault: cover property (s.pd_fault);
	c_restart_done: cover property ((s.arb == ANP_ARB_DONE) ##1 (s.arb == ANP_ARB_IDLE));

endmodule

// File: core/anp_pkg.sv
// anp_pkg: constants and shared types of the negotiation and parallel detect block
package anp_pkg;

	// ************************************************************
	// register word indices (byte address is four times the index)
	// ************************************************************
	localparam logic [4:0]  ANP_IDX_CTRL    = 5'h00;
	localparam logic [4:0]  ANP_IDX_STAT    = 5'h01;
	localparam logic [4:0]  ANP_IDX_ADV     = 5'h04;
	localparam logic [4:0]  ANP_IDX_LPA     = 5'h05;
	localparam logic [4:0]  ANP_IDX_EXP     = 5'h06;
	localparam logic [4:0]  ANP_IDX_QSTAT   = 5'h11;
	localparam logic [4:0]  ANP_IDX_RFLT    = 5'h13;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int          ANP_CTL_SWRST   = 15;
	localparam int          ANP_CTL_ANEN    = 12;
	localparam int          ANP_CTL_RESTART = 9;
	localparam int          ANP_ST_COMPLETE = 5;
	localparam int          ANP_ST_RFAULT   = 4;
	localparam int          ANP_ST_ANABLE   = 3;
	localparam int          ANP_ST_LINK     = 2;
	localparam int          ANP_AB_10HD     = 5;
	localparam int          ANP_AB_10FD     = 6;
	localparam int          ANP_AB_100HD    = 7;
	localparam int          ANP_AB_100FD    = 8;
	localparam int          ANP_AB_T4       = 9;
	localparam int          ANP_AB_RF       = 13;
	localparam int          ANP_EXP_LPABLE  = 0;
	localparam int          ANP_EXP_PDFAULT = 4;
	localparam int          ANP_QS_LINK     = 0;
	localparam int          ANP_QS_RF       = 1;
	localparam int          ANP_QS_SIGNONE  = 3;
	localparam int          ANP_QS_COMPLETE = 4;
	localparam int          ANP_QS_PROG_LSB = 8;
	localparam int          ANP_QS_FULLDUP  = 14;
	localparam int          ANP_QS_SPEED100 = 15;
	localparam int          ANP_RFLT_BIT    = 13;

	// ************************************************************
	// reset values and masks
	// ************************************************************
	localparam logic [15:0] ANP_STAT_CAPS   = 16'h7800;
	localparam logic [15:0] ANP_ADV_RESET   = 16'h01e1;
	localparam logic [15:0] ANP_ADV_WMASK   = 16'h21ff;

	// ************************************************************
	// progress monitor codes (higher means further along)
	// ************************************************************
	localparam logic [2:0]  ANP_PROG_IDLE   = 3'h0;
	localparam logic [2:0]  ANP_PROG_ABIL   = 3'h1;
	localparam logic [2:0]  ANP_PROG_ACK    = 3'h2;
	localparam logic [2:0]  ANP_PROG_LCHK   = 3'h3;
	localparam logic [2:0]  ANP_PROG_DONE   = 3'h4;

	// ************************************************************
	// timing and bus codes
	// ************************************************************
	localparam int          ANP_NEG_TIME_MS = 500;
	localparam int          ANP_CLK_KHZ     = 40000;
	localparam int          ANP_NEG_CYCLES  = ANP_NEG_TIME_MS * ANP_CLK_KHZ;
	localparam int          ANP_TIMER_W     = 25;
	localparam logic [1:0]  ANP_HTRANS_NSEQ = 2'h2;
	localparam logic        ANP_HRESP_OKAY  = 1'b0;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		ANP_ARB_IDLE = 3'h0,
		ANP_ARB_ABIL = 3'h1,
		ANP_ARB_ACK  = 3'h3,
		ANP_ARB_LCHK = 3'h2,
		ANP_ARB_DONE = 3'h6
	} anp_arb_e;

	typedef struct packed {
		logic flp;
		logic nlp;
		logic idle100;
		logic signal;
		logic link_ok;
	} anp_media_s;

	typedef struct packed {
		logic en_100tx;
		logic en_10t;
		logic full_duplex;
	} anp_tech_s;

endpackage

// File: core/anp_sync.sv
// anp_sync: three-stage synchroniser for pin-level media indications
`timescale 1ns/10ps

module anp_sync
	import anp_pkg::*;
#(
	parameter int W = 5
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// raw pins and filtered result
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] q;
	} anp_sync_s;

	anp_sync_s s;
	anp_sync_s next_s;

	// ff1 feeds only ff2; a bit moves only once ff2 and ff3 agree,
	// which drops single-cycle glitches at the cost of one more cycle
	always_comb begin
		next_s     = s;
		next_s.ff1 = din;
		next_s.ff2 = s.ff1;
		next_s.ff3 = s.ff2;
		next_s.q   = (s.ff3 & ~(s.ff2 ^ s.ff3)) | (s.q & (s.ff2 ^ s.ff3));
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.q;

endmodule
